// ===== sim/cls_mgmt_station.sv
/*
 * Management station model: issues one APB transfer at a time to the stopwatch.
 * Assumes the caller enters xfer just after a rising edge of clk_in.
 */
`timescale 1ns/1ps
module cls_mgmt_station
    import cls_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  pready_in,
    output logic      [CLS_ADDR_W-1:0] paddr_out,
    output logic                       psel_out,
    output logic                       penable_out,
    output logic                       pwrite_out,
    output logic      [31:0]           pwdata_out
);
    initial begin
        paddr_out   = '0;
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        pwdata_out  = '0;
    end

    // The wait for pready is bounded; ok stays low if the slave never answers.
    task automatic xfer(input logic wr, input logic [CLS_ADDR_W-1:0] a, input logic [31:0] d, output logic ok);
        ok = 1'b0;
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= wr;
        paddr_out   <= a;
        pwdata_out  <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        for (int i = 0; i < 16 && ok !== 1'b1; i++) begin
            @(posedge clk_in);
            ok = (pready_in === 1'b1);
        end
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // Released data is inverted so nothing can lean on a stale value.
        pwdata_out  <= ~d;
        @(posedge clk_in);
    endtask : xfer
endmodule : cls_mgmt_station

// ===== sim/tb_comma_latency_stopwatch.sv
/*
 * Self-checking bench for the comma latency stopwatch.
 * Assumes the management station model drives the APB side.
 */
`timescale 1ns/1ps
module tb_comma_latency_stopwatch
    import cls_pkg::*;
;
    typedef struct packed {
        logic        err;
        logic [31:0] v;
        logic [31:0] tol;
    } cls_exp_t;

    cls_exp_t                          q[$];
    cls_exp_t                          e;
    logic                              ok_v;
    logic                              clk_in = 1'b0;
    logic                              srst_in = 1'b1;
    logic [CLS_NUM_CHAN-1:0]           bit_tick = '0;
    logic [CLS_NUM_CHAN-1:0]           byte_tick = '0;
    logic                              pin = 1'b0;
    cls_chan_taps_t [CLS_NUM_CHAN-1:0] taps = '0;
    logic [7:0]                        cnt = '0;
    logic [7:0]                        kc [3];
    wire  [CLS_ADDR_W-1:0]             paddr;
    wire                               psel, penable, pwrite;
    wire  [31:0]                       pwdata, prdata;
    wire                               pready, pslverr;
    int                                mismatches = 0;
    int                                num_checks = 0;

    always #20 clk_in = ~clk_in;

    // Channel 1 ticks at a different rate so a wrong channel clock shows.
    always @(posedge clk_in) begin
        cnt       <= cnt + 8'h01;
        byte_tick <= {cnt[0] == 1'b0, cnt[1:0] == 2'b00};
        bit_tick  <= {cnt[0], 1'b1};
    end

    cls_stopwatch uut (.clk_in(clk_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .taps_in(taps), .bit_tick_in(bit_tick),
        .byte_tick_in(byte_tick), .port_address_low_pin_in(pin));

    cls_mgmt_station mgmt (.clk_in(clk_in), .pready_in(pready), .paddr_out(paddr), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .pwdata_out(pwdata));

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0 && q.size() == 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge clk_in) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            e = q.pop_front();
            num_checks++;
            ok_v = (pslverr === e.err) && ((prdata - e.v + e.tol) <= (e.tol << 1));
            if (ok_v !== 1'b1) begin
                mismatches++;
                $display("[ERR] t=%0t got %h exp %h", $time, prdata, e.v);
            end
        end
    end

    task automatic wr(input logic [CLS_ADDR_W-1:0] a, input logic [31:0] d);
        logic ok;
        mgmt.xfer(1'b1, a, d, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask : wr

    task automatic rd(input logic [CLS_ADDR_W-1:0] a, input logic [31:0] v, input int tol, input logic err);
        logic ok;
        q.push_back({err, v, 32'(tol)});
        mgmt.xfer(1'b0, a, 32'h0, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask : rd

    task automatic send(input int ch, input logic stp, input logic sel, input logic [7:0] d);
        cls_chan_taps_t [CLS_NUM_CHAN-1:0] t;
        t = '0;
        if (stp) t[ch].stop[sel] = {2'b11, d};
        else t[ch].start[sel] = {2'b11, d};
        taps <= t;
        @(posedge clk_in);
    endtask : send

    task automatic idle(input int n);
        taps <= '0;
        repeat (n) @(posedge clk_in);
    endtask : idle

    task automatic meas(input int ch, input logic ss, input logic sp, input logic [7:0] d0, input logic [7:0] d1,
                        input logic [10:0] mode, input int l, input int h);
        logic [31:0] c;
        c = 32'(mode);
        c[CLS_CTRL_ARM] = 1'b1;
        c[CLS_CTRL_CHAN] = ch[0];
        c[CLS_CTRL_START_SEL] = ss;
        c[CLS_CTRL_STOP_SEL] = sp;
        wr(CLS_ADDR_CTRL, c);
        send(ch, 1'b0, ss, 8'h1c);
        send(ch, 1'b0, ~ss, d0);
        send(ch, 1'b0, ss, d0);
        idle(h);
        send(ch, 1'b0, ss, d1);
        send(ch, 1'b1, ~sp, d1);
        send(ch ^ 1, 1'b1, sp, d1);
        idle(h);
        send(ch, 1'b1, sp, d0);
        send(ch, 1'b0, ss, d0);
        send(ch, 1'b1, sp, d1);
        idle(3);
        rd(CLS_ADDR_STATUS, 32'h4, 0, 1'b0);
        rd(CLS_ADDR_RESULT, 32'((2 * h + 4) / l), 1, 1'b0);
        rd(CLS_ADDR_STATUS, 32'h0, 0, 1'b0);
    endtask : meas

    initial begin
        repeat (100000) @(posedge clk_in);
        mismatches++;
        close_out();
    end

    initial begin
        int l;
        int w;
        void'($urandom(32'h55ac62bf));
        kc[0] = CLS_K28_1;
        kc[1] = CLS_K28_5;
        kc[2] = CLS_K28_7;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        rd(CLS_ADDR_CTRL, 32'h0, 0, 1'b0);
        rd(CLS_ADDR_RESULT, 32'h0, 0, 1'b0);
        rd(12'h00c, 32'h0, 0, 1'b1);
        wr(CLS_ADDR_CTRL, 32'h7fe);
        rd(CLS_ADDR_CTRL, 32'h7fe, 0, 1'b0);
        wr(CLS_ADDR_CTRL, 32'h1);
        rd(CLS_ADDR_STATUS, 32'h1, 0, 1'b0);
        wr(CLS_ADDR_RESULT, 32'hfffff);
        rd(CLS_ADDR_RESULT, 32'h0, 0, 1'b0);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            meas(i % 2, i[1], i[0] ^ i[1], kc[i % 3], kc[(i + 1) % 3], 11'h100, (i % 2) ? 2 : 4,
                 4 + $urandom % 12);
        end
        $display("byte clock done");
        // Rate and divider sweep; the wide windows stand in for divided long runs.
        for (int r = 0; r < 4; r++) begin
            for (int dv = 0; dv < 4; dv++) begin
                l = ((8 >> r) << dv) * ((dv % 2) ? 2 : 1);
                meas(dv % 2, 1'b0, 1'b0, CLS_K28_5, CLS_K28_5, 11'((r << 4) | (dv << 6)), l,
                     4 * l + $urandom % l);
            end
        end
        $display("fast clock done");
        w = 40 + 4 * ($urandom % 10);
        wr(CLS_ADDR_CTRL, 32'h701);
        pin <= 1'b1;
        repeat (w) @(posedge clk_in);
        pin <= 1'b0;
        repeat (8) @(posedge clk_in);
        rd(CLS_ADDR_STATUS, 32'h4, 0, 1'b0);
        rd(CLS_ADDR_RESULT, 32'(w / 4), 1, 1'b0);
        $display("pin mode done");
        close_out();
    end
endmodule : tb_comma_latency_stopwatch

// ===== src/cls_pkg.sv
// What this block does
// [R1] Two start and two stop points selectable.
// [R2] Measure start comma to stop comma time.
// [R3] Only one selected channel measured.
// [R4] Commas are K28.1, K28.5, K28.7 controls.
// [R5] First start comma starts; later ignored.
// [R6] First stop comma halts, freezing value.
// [R7] Result is a readable 20-bit counter.
// [R8] Overrange result reads all ones.
// [R9] One result held until software reads.
// [R10] Pin level may start or stop instead.
// [R11] Full rate: bit rate over eight.
// [R12] Half rate: bit rate over four.
// [R13] Quarter rate: bit rate over two.
// [R14] Eighth rate: bit rate undivided.
// [R15] Extra divider by 1, 2, 4, 8.
// [R16] Count clock from the selected channel.
// [R17] Byte clock source gives bit rate/20.
// [R18] Accuracy within one count period.
// [R19] Software uses fast clock only at CPRI/OBSAI rates.
// [R20] Software divides for intervals above 682us.
// [R21] Serializer front end lies outside count.
// [R22] Arming clears the counter to zero; an arm while a result is held in CLS_DONE is ignored and leaves the count.
/*
 * Constants, field layouts and carrier types of the comma latency stopwatch.
 * Assumes a single 25 MHz clock and an APB master with 32-bit data.
 */
package cls_pkg;

    localparam int unsigned CLS_CNT_W      = 20;
    localparam int unsigned CLS_NUM_CHAN   = 2;
    localparam int unsigned CLS_ADDR_W     = 12;
    localparam int unsigned CLS_DIVCNT_W   = 7;

    localparam logic [CLS_CNT_W-1:0] CLS_RESULT_MAX = 20'hfffff;
    localparam logic [CLS_CNT_W-1:0] CLS_RESULT_RST = 20'h00000;

    localparam logic [7:0] CLS_K28_1 = 8'h3c;
    localparam logic [7:0] CLS_K28_5 = 8'hbc;
    localparam logic [7:0] CLS_K28_7 = 8'hfc;

    localparam logic [CLS_ADDR_W-1:0] CLS_ADDR_CTRL   = 12'h000;
    localparam logic [CLS_ADDR_W-1:0] CLS_ADDR_STATUS = 12'h004;
    localparam logic [CLS_ADDR_W-1:0] CLS_ADDR_RESULT = 12'h008;

    localparam int unsigned CLS_CTRL_ARM       = 0;
    localparam int unsigned CLS_CTRL_CHAN      = 1;
    localparam int unsigned CLS_CTRL_START_SEL = 2;
    localparam int unsigned CLS_CTRL_STOP_SEL  = 3;
    localparam int unsigned CLS_CTRL_RATE_LO   = 4;
    localparam int unsigned CLS_CTRL_DIV_LO    = 6;
    localparam int unsigned CLS_CTRL_BYTE_SRC  = 8;
    localparam int unsigned CLS_CTRL_PIN_START = 9;
    localparam int unsigned CLS_CTRL_PIN_STOP  = 10;
    localparam int unsigned CLS_CTRL_W         = 11;
    localparam logic [CLS_CTRL_W-1:0] CLS_CTRL_RST = 11'h000;

    localparam int unsigned CLS_STAT_ARMED = 0;
    localparam int unsigned CLS_STAT_COUNT = 1;
    localparam int unsigned CLS_STAT_VALID = 2;

    localparam logic [1:0] CLS_RATE_FULL    = 2'h0;
    localparam logic [1:0] CLS_RATE_HALF    = 2'h1;
    localparam logic [1:0] CLS_RATE_QUARTER = 2'h2;
    localparam logic [1:0] CLS_RATE_EIGHTH  = 2'h3;

    localparam logic [CLS_DIVCNT_W-1:0] CLS_PREDIV_FULL    = 7'h08;
    localparam logic [CLS_DIVCNT_W-1:0] CLS_PREDIV_HALF    = 7'h04;
    localparam logic [CLS_DIVCNT_W-1:0] CLS_PREDIV_QUARTER = 7'h02;
    localparam logic [CLS_DIVCNT_W-1:0] CLS_PREDIV_EIGHTH  = 7'h01;

    typedef struct packed {
        logic       valid;
        logic       ctrl;
        logic [7:0] data;
    } cls_sym_t;

    typedef struct packed {
        cls_sym_t [1:0] start;
        cls_sym_t [1:0] stop;
    } cls_chan_taps_t;

    typedef enum logic [3:0] {
        CLS_IDLE  = 4'b0001,
        CLS_ARMED = 4'b0010,
        CLS_COUNT = 4'b0100,
        CLS_DONE  = 4'b1000
    } cls_state_t;

endpackage : cls_pkg

// ===== src/cls_stopwatch.sv
/*
 * Comma latency stopwatch: APB register slave, count clock divider,
 * comma detection on the selected channel and the 20-bit result counter.
 * Assumes comma taps and clock ticks come from logic on clk_in; only the
 * port address pin is asynchronous.
 */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cls_stopwatch
    import cls_pkg::*;
(
    input  wire logic                                   clk_in,
    input  wire logic                                   srst_in,
    input  wire logic [CLS_ADDR_W-1:0]                  paddr_in,
    input  wire logic                                   psel_in,
    input  wire logic                                   penable_in,
    input  wire logic                                   pwrite_in,
    input  wire logic [31:0]                            pwdata_in,
    output logic      [31:0]                            prdata_out,
    output logic                                        pready_out,
    output logic                                        pslverr_out,
    input  wire cls_chan_taps_t [CLS_NUM_CHAN-1:0]      taps_in,
    input  wire logic [CLS_NUM_CHAN-1:0]                bit_tick_in,
    input  wire logic [CLS_NUM_CHAN-1:0]                byte_tick_in,
    input  wire logic                                   port_address_low_pin_in
);

    logic [CLS_CTRL_W-1:0]   ctrl_reg;
    cls_state_t              state_reg;
    cls_state_t              state_next;
    logic [CLS_CNT_W-1:0]    count_reg;
    logic [CLS_DIVCNT_W-1:0] div_cnt_reg;
    logic [CLS_DIVCNT_W-1:0] div_lim;
    logic [CLS_DIVCNT_W-1:0] prediv;
    logic                    meas_tick_reg;
    logic [2:0]              pin_sync_reg;
    logic                    pin_level_reg;
    logic [31:0]             prdata_reg;
    logic                    pready_reg;
    logic                    pslverr_reg;

    logic                    apb_setup;
    logic                    apb_access;
    logic                    addr_ok;
    logic                    arm_req;
    logic                    rd_result;
    logic                    chan;
    logic                    start_hit;
    logic                    stop_hit;
    logic                    sel_bit_tick;
    logic                    byte_src;
    cls_sym_t                start_sym;
    cls_sym_t                stop_sym;

    // [R4] Comma recognition.
    function automatic logic is_comma(input cls_sym_t s);
        is_comma = s.valid && s.ctrl &&
                   (s.data == CLS_K28_1 || s.data == CLS_K28_5 || s.data == CLS_K28_7);
    endfunction : is_comma

    assign apb_setup  = psel_in && !penable_in;
    assign apb_access = psel_in && penable_in && pready_reg;
    assign addr_ok    = (paddr_in == CLS_ADDR_CTRL) || (paddr_in == CLS_ADDR_STATUS) ||
                        (paddr_in == CLS_ADDR_RESULT);
    assign arm_req    = apb_access && pwrite_in && (paddr_in == CLS_ADDR_CTRL) &&
                        pwdata_in[CLS_CTRL_ARM];
    assign rd_result  = apb_access && !pwrite_in && (paddr_in == CLS_ADDR_RESULT);

    // [R3] One channel at a time.
    assign chan       = ctrl_reg[CLS_CTRL_CHAN];
    // [R1] Start and stop point select.
    assign start_sym  = taps_in[chan].start[ctrl_reg[CLS_CTRL_START_SEL]];
    assign stop_sym   = taps_in[chan].stop[ctrl_reg[CLS_CTRL_STOP_SEL]];

    // [R10] Pin may replace comma.
    assign start_hit  = ctrl_reg[CLS_CTRL_PIN_START] ? pin_level_reg : is_comma(start_sym);
    assign stop_hit   = ctrl_reg[CLS_CTRL_PIN_STOP] ? !pin_level_reg : is_comma(stop_sym);

    // [R16] Tick from the selected channel.
    assign sel_bit_tick = bit_tick_in[chan];
    assign byte_src     = ctrl_reg[CLS_CTRL_BYTE_SRC];

    // [R11] [R12] [R13] [R14] Rate prescale.
    always_comb begin
        case (ctrl_reg[CLS_CTRL_RATE_LO +: 2])
            CLS_RATE_FULL:    prediv = CLS_PREDIV_FULL;
            CLS_RATE_HALF:    prediv = CLS_PREDIV_HALF;
            CLS_RATE_QUARTER: prediv = CLS_PREDIV_QUARTER;
            CLS_RATE_EIGHTH:  prediv = CLS_PREDIV_EIGHTH;
            default:          prediv = CLS_PREDIV_FULL;
        endcase
    end

    // [R15] Post divider by 1, 2, 4, 8.
    assign div_lim = prediv << ctrl_reg[CLS_CTRL_DIV_LO +: 2];

    // [R11] Count clock enable from bit ticks.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_cnt_reg <= '0;
        end else if (byte_src) begin
            div_cnt_reg <= '0;
        end else if (sel_bit_tick) begin
            if (div_cnt_reg >= div_lim - 7'h01) begin
                div_cnt_reg <= '0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 7'h01;
            end
        end
    end

    // [R17] Byte clock or divided bit clock.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meas_tick_reg <= 1'b0;
        end else if (byte_src) begin
            meas_tick_reg <= byte_tick_in[chan];
        end else begin
            meas_tick_reg <= sel_bit_tick && (div_cnt_reg >= div_lim - 7'h01);
        end
    end

    // The pin is asynchronous, so a level counts only once two late stages agree.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], port_address_low_pin_in};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_level_reg <= pin_sync_reg[2];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_reg <= CLS_CTRL_RST;
        end else if (apb_access && pwrite_in && paddr_in == CLS_ADDR_CTRL) begin
            ctrl_reg <= pwdata_in[CLS_CTRL_W-1:0] & ~(11'h001 << CLS_CTRL_ARM);
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CLS_IDLE: begin
                if (arm_req) begin
                    state_next = CLS_ARMED;
                end
            end
            CLS_ARMED: begin
                // [R5] First start event begins counting.
                if (start_hit) begin
                    state_next = CLS_COUNT;
                end
            end
            CLS_COUNT: begin
                // [R6] First stop event halts.
                if (stop_hit) begin
                    state_next = CLS_DONE;
                end
            end
            CLS_DONE: begin
                // [R9] Held until the result is read.
                if (rd_result) begin
                    state_next = CLS_IDLE;
                end
            end
            default: state_next = CLS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= CLS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // A stop seen in the same cycle as a tick drops that tick; the error stays
    // within one count period either way.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= CLS_RESULT_RST;
        // [R22] Arming clears the count.
        end else if (arm_req && state_reg != CLS_DONE) begin
            count_reg <= CLS_RESULT_RST;
        // [R2] [R18] Count one per tick.
        end else if (state_reg == CLS_COUNT && !stop_hit && meas_tick_reg) begin
            // [R8] Saturate at all ones.
            if (count_reg != CLS_RESULT_MAX) begin
                count_reg <= count_reg + 20'h00001;
            end
        end
    end

    // Zero wait states: the answer is ready by the end of the setup cycle.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (apb_setup) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !addr_ok;
            prdata_reg  <= 32'h0000_0000;
            if (!pwrite_in) begin
                case (paddr_in)
                    CLS_ADDR_CTRL: prdata_reg <= {21'h000000, ctrl_reg};
                    CLS_ADDR_STATUS: prdata_reg <= {29'h00000000, state_reg == CLS_DONE,
                                                    state_reg == CLS_COUNT, state_reg == CLS_ARMED};
                    // [R7] Result readable.
                    CLS_ADDR_RESULT: prdata_reg <= {12'h000, count_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata_out  = prdata_reg;
    assign pready_out  = pready_reg;
    assign pslverr_out = pslverr_reg;

    // [R21] The taps sit after the serializer front end, so its delay is never counted.

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    sequence s_armed_start;
        state_reg == CLS_ARMED && start_hit;
    endsequence

    sequence s_counting;
        state_reg == CLS_COUNT;
    endsequence

    a_start_on_comma: assert property ( // [R5]
        s_armed_start |=> s_counting)
        else $error("Start event did not begin counting.");

    a_no_restart: assert property ( // [R5]
        state_reg == CLS_COUNT && start_hit && !stop_hit && count_reg != CLS_RESULT_MAX
        |=> count_reg == $past(count_reg) || count_reg == $past(count_reg) + 20'h00001)
        else $error("Start event disturbed a running count.");

    a_stop_freezes: assert property ( // [R6]
        s_counting ##0 stop_hit ##1 (state_reg == CLS_DONE && !arm_req && !rd_result)
        |=> $stable(count_reg))
        else $error("Result changed after stop.");

    a_count_sat: assert property ( // [R8]
        state_reg == CLS_COUNT && count_reg == CLS_RESULT_MAX |=> count_reg == CLS_RESULT_MAX)
        else $error("Counter wrapped past all ones.");

    a_result_held: assert property ( // [R9]
        state_reg == CLS_DONE && !rd_result |=> state_reg == CLS_DONE && $stable(count_reg))
        else $error("Stored result replaced before read.");

    a_arm_clears: assert property ( // [R22]
        state_reg == CLS_IDLE && arm_req |=> state_reg == CLS_ARMED && count_reg == CLS_RESULT_RST)
        else $error("Arming did not clear the counter.");

    a_tick_divide: assert property ( // [R15]
        !byte_src && sel_bit_tick && div_cnt_reg >= div_lim - 7'h01 && $stable(ctrl_reg)
        |=> meas_tick_reg)
        else $error("Divided count tick missing.");

    a_tick_spacing: assert property ( // [R11]
        !byte_src && ctrl_reg[CLS_CTRL_RATE_LO +: 2] == CLS_RATE_FULL && ctrl_reg[CLS_CTRL_DIV_LO +: 2] == 2'h0
        && meas_tick_reg && $stable(ctrl_reg) |-> div_cnt_reg == 7'h00)
        else $error("Full rate tick not on divide by eight boundary.");

    a_byte_source: assert property ( // [R17]
        byte_src && $stable(ctrl_reg) |=> meas_tick_reg == $past(byte_tick_in[chan]))
        else $error("Byte clock tick not forwarded.");

    a_apb_answer: assert property (
        apb_setup |=> pready_out ##1 !pready_out)
        else $error("APB answer not in one cycle.");

    sequence s_done;
        state_reg == CLS_DONE;
    endsequence

    a_stop_done: assert property ( // [R6]
        s_counting ##0 stop_hit |=> s_done)
        else $error("Stop event did not end counting.");

    a_read_frees: assert property ( // [R9]
        s_done ##0 rd_result |=> state_reg == CLS_IDLE)
        else $error("Result read did not free the storage.");

    a_armed_waits: assert property ( // [R5]
        state_reg == CLS_ARMED && !start_hit |=> state_reg == CLS_ARMED)
        else $error("Count began without a start event.");

    a_comma_only: assert property ( // [R4]
        state_reg == CLS_ARMED && !ctrl_reg[CLS_CTRL_PIN_START] && !is_comma(start_sym)
        |=> state_reg == CLS_ARMED)
        else $error("Non comma symbol started the count.");

    a_pin_start: assert property ( // [R10]
        state_reg == CLS_ARMED && ctrl_reg[CLS_CTRL_PIN_START] && pin_level_reg |=> s_counting)
        else $error("Pin high did not start the count.");

    a_pin_stop: assert property ( // [R10]
        s_counting ##0 (ctrl_reg[CLS_CTRL_PIN_STOP] && !pin_level_reg) |=> s_done)
        else $error("Pin low did not stop the count.");

    a_pin_agree: assert property ( // [R10]
        pin_sync_reg[1] == pin_sync_reg[2] |=> pin_level_reg == $past(pin_sync_reg[2]))
        else $error("Agreed pin level not taken.");

    a_idle_holds: assert property ( // [R2]
        (state_reg == CLS_IDLE || state_reg == CLS_ARMED) && !arm_req |=> $stable(count_reg))
        else $error("Counter moved outside a measurement.");

    a_count_step: assert property ( // [R2]
        state_reg == CLS_COUNT && !stop_hit && meas_tick_reg && !arm_req && count_reg != CLS_RESULT_MAX
        |=> count_reg == $past(count_reg) + 20'h00001)
        else $error("Count tick not added.");

    a_no_tick_hold: assert property ( // [R18]
        state_reg == CLS_COUNT && !meas_tick_reg && !arm_req |=> $stable(count_reg))
        else $error("Counter moved without a tick.");

    a_arm_rearm: assert property ( // [R22]
        arm_req && state_reg != CLS_DONE |=> count_reg == CLS_RESULT_RST)
        else $error("Arming left a stale count.");

    a_byte_no_div: assert property ( // [R17]
        byte_src |=> div_cnt_reg == 7'h00)
        else $error("Divider ran while byte clock selected.");

    a_chan_tick: assert property ( // [R16]
        !byte_src && !sel_bit_tick |=> !meas_tick_reg)
        else $error("Tick without a tick of the selected channel.");

    a_slverr_map: assert property (
        apb_setup && !addr_ok |=> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("Unmapped address not refused.");

    a_result_width: assert property ( // [R7]
        pready_out |-> prdata_out[31:20] == 12'h000)
        else $error("Read data upper bits not zero.");

endmodule : cls_stopwatch
